// file: smw_pkg.sv
// Purpose: Shared constants, types and helpers for the serial memory write link
// Assumes: Both ends agree on lane use per opcode and protocol
// Notes: Host link clock period is eight system clocks

package smw_pkg;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_DDRW = 8'hde;
  localparam logic [7:0] OP_FAST = 8'hda;
  localparam logic [7:0] OP_DDRFAST = 8'hdd;
  localparam logic [7:0] OP_TWO_DATA = 8'ha2;
  localparam logic [7:0] OP_TWO_ALL = 8'ha1;
  localparam logic [7:0] OP_FOUR_DATA = 8'h32;
  localparam logic [7:0] OP_FOUR_ALL = 8'hd2;
  localparam logic [7:0] OP_DDR_FOUR = 8'hd1;

  // ----------------------------------------
  // Link format
  // ----------------------------------------
  localparam int AW = 19;
  localparam logic [3:0] SKIP_KEY = 4'ha;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [1:0] PROTO_SPI = 2'h0;
  localparam logic [1:0] PROTO_TWO = 2'h1;
  localparam logic [1:0] PROTO_FOUR = 2'h2;

  // ----------------------------------------
  // Host link clock phases (8 clocks a period)
  // ----------------------------------------
  localparam logic [2:0] SCK_RISE_PH = 3'h3;
  localparam logic [2:0] SCK_FALL_PH = 3'h7;
  localparam logic [2:0] SDR_SLOT_PH = 3'h0;
  localparam logic [2:0] DDR_SLOT_A = 3'h1;
  localparam logic [2:0] DDR_SLOT_B = 3'h5;

  // ----------------------------------------
  // Host register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam int CTRL_PROTO_LSB = 8;
  localparam int CTRL_SKIP_BIT = 10;
  localparam int CTRL_CNT_LSB = 11;
  localparam int CTRL_GO_BIT = 31;
  localparam int STAT_BUSY_BIT = 0;

  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_MODE, PH_DATA} smw_ph_t;

  // ----------------------------------------
  // Lanes used by a command phase
  // ----------------------------------------
  function automatic logic [2:0] smw_lanes(input logic [7:0] op, input logic [1:0] proto, input smw_ph_t ph);
    logic [2:0] pw;
    pw = (proto == PROTO_FOUR) ? 3'h4 : (proto == PROTO_TWO) ? 3'h2 : 3'h1;
    if (ph == PH_CMD) return pw;
    case (op)
      OP_TWO_DATA: return (ph == PH_DATA) ? 3'h2 : 3'h1;
      OP_TWO_ALL: return 3'h2;
      OP_FOUR_DATA: return (ph == PH_DATA) ? 3'h4 : 3'h1;
      OP_FOUR_ALL, OP_DDR_FOUR: return 3'h4;
      default: return pw;
    endcase
  endfunction

  function automatic logic smw_has_mode(input logic [7:0] op);
    return op inside {OP_FAST, OP_DDRFAST, OP_TWO_DATA, OP_TWO_ALL, OP_FOUR_DATA, OP_FOUR_ALL, OP_DDR_FOUR};
  endfunction

  function automatic logic smw_ddr(input logic [7:0] op);
    return op inside {OP_DDRW, OP_DDRFAST, OP_DDR_FOUR};
  endfunction

  function automatic logic smw_known(input logic [7:0] op);
    return (op == OP_WRITE) || (op == OP_DDRW) || smw_has_mode(op);
  endfunction
endpackage

// file: smw_if.sv
// Purpose: Serial link between host controller and memory device
// Assumes: Undriven data lines are pulled high
// Notes: Device never drives; write commands only

`timescale 1ns/1ns

interface smw_if;
  logic cs_n;
  logic sck;
  logic [3:0] io_o;
  logic [3:0] io_oe;
  wire [3:0] io;

  assign io = (io_o & io_oe) | ~io_oe;

  modport host (output cs_n, output sck, output io_o, output io_oe);
  modport dev (input cs_n, input sck, input io);
endinterface

// file: smw_dev.sv
// Purpose: Memory-side interpreter of serial write commands
// Assumes: Link pins are asynchronous to clk; sck at most clk/6
// Notes: Array itself sits outside; this block emits byte writes
//
// Functional notes
// - Opcode, three address bytes, mode, then data
// - Nineteen address bits used; top five ignored
// - Data follows address or mode without gap
// - Unlimited bursts at bus speed, no waits
// - Protected bytes skipped while address advances
// - Partial byte at deselect is discarded
// - Decode 02, DE, DA, DD opcodes
// - A2 data two lines; A1 address onward two
// - 32 data four lines; D2/D1 address onward four
// - Plain write follows one, two or four lanes
// - Burst auto-increments while select stays low
// - Address wraps from top to zero
// - Plain write needs write latch flag set
// - Plain write leaves latch flag set
// - Dual-edge write samples on both edges
// - Host uses clock mode 0 for dual-edge
// - Dual-edge and skip writes need flag, keep it
// - Mode nibble 1010 enters opcode skip mode
// - Other mode byte leaves opcode skip mode
// - Two-line bytes: bit 7 on line 1

`timescale 1ns/1ns

module smw_dev (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  smw_if.dev bus,
  // Device settings
  input wire logic [1:0] proto,
  input wire logic write_latch_flag,
  input wire logic prot_en,
  input wire logic [smw_pkg::AW-1:0] prot_lo,
  input wire logic [smw_pkg::AW-1:0] prot_hi,
  // Array write port
  output logic mem_we,
  output logic [smw_pkg::AW-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  // Status
  output logic cont_mode
);
  import smw_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DATA, ST_IGN} smw_dst_t;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    smw_dst_t st;
    logic [7:0] op;
    logic [7:0] sh;
    logic [3:0] nb;
    logic [1:0] ab;
    logic [23:0] addr;
    logic cont;
    logic we;
    logic [AW-1:0] waddr;
    logic [7:0] wdata;
  } smw_dev_t;

  smw_dev_t s_r;
  smw_dev_t s_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [2:0] w;
    logic [3:0] nb;
    logic [7:0] b;
    logic rise;
    logic fall;
    logic ddr;
    logic prot;
    smw_ph_t ph;
    w = 3'h1;
    nb = 4'h0;
    b = 8'h00;
    ph = PH_CMD;
    rise = 1'b0;
    fall = 1'b0;
    ddr = 1'b0;
    prot = 1'b0;
    s_nxt = s_r;
    // Three flip-flops on select and clock, two on each data pin
    s_nxt.cs_s = {s_r.cs_s[1:0], bus.cs_n};
    s_nxt.sck_s = {s_r.sck_s[1:0], bus.sck};
    s_nxt.io_s1 = bus.io;
    s_nxt.io_s2 = s_r.io_s1;
    s_nxt.we = 1'b0;
    // Link clock edges, aligned with the data samples
    rise = s_r.sck_s[1] & ~s_r.sck_s[2];
    fall = ~s_r.sck_s[1] & s_r.sck_s[2];
    case (s_r.st)
      ST_ADDR: ph = PH_ADDR;
      ST_MODE: ph = PH_MODE;
      ST_DATA: ph = PH_DATA;
      default: ph = PH_CMD;
    endcase
    w = smw_lanes(s_r.op, proto, ph);
    ddr = smw_ddr(s_r.op) && (s_r.st != ST_CMD);
    prot = prot_en &&
      (s_r.addr[AW-1:0] >= prot_lo) &&
      (s_r.addr[AW-1:0] <= prot_hi);
    // Shift in msb first; two lanes put bit 7 on line 1
    if (w == 3'h4) begin
      b = {s_r.sh[3:0], s_r.io_s2};
    end else if (w == 3'h2) begin
      b = {s_r.sh[5:0], s_r.io_s2[1:0]};
    end else begin
      b = {s_r.sh[6:0], s_r.io_s2[0]};
    end
    nb = s_r.nb + {1'b0, w};
    if (s_r.cs_s[1]) begin
      // Deselect drops any partial byte
      s_nxt.st = ST_IDLE;
    end else if (s_r.cs_s[2]) begin
      s_nxt.nb = 4'h0;
      s_nxt.sh = 8'h00;
      s_nxt.ab = 2'h0;
      if (s_r.cont) begin
        s_nxt.st = write_latch_flag ? ST_ADDR : ST_IGN;
      end else begin
        s_nxt.st = ST_CMD;
      end
    end else if ((rise || (ddr && fall)) && (s_r.st != ST_IDLE) && (s_r.st != ST_IGN)) begin
      s_nxt.sh = b;
      s_nxt.nb = nb;
      if (nb == BYTE_BITS) begin
        s_nxt.nb = 4'h0;
        unique case (s_r.st)
          ST_CMD: begin
            s_nxt.op = b;
            // Unknown opcode or flag clear: ignore to deselect
            s_nxt.st = (smw_known(b) && write_latch_flag) ? ST_ADDR : ST_IGN;
          end
          ST_ADDR: begin
            s_nxt.addr = {s_r.addr[15:0], b};
            s_nxt.ab = s_r.ab + 2'h1;
            if (s_r.ab == ADDR_LAST) begin
              s_nxt.st = smw_has_mode(s_r.op) ? ST_MODE : ST_DATA;
            end
          end
          ST_MODE: begin
            s_nxt.cont = (b[7:4] == SKIP_KEY);
            s_nxt.st = ST_DATA;
          end
          ST_DATA: begin
            if (!prot) begin
              s_nxt.we = 1'b1;
              s_nxt.waddr = s_r.addr[AW-1:0];
              s_nxt.wdata = b;
            end
            // Counter advances even over protected bytes and wraps at top
            s_nxt.addr[AW-1:0] = s_r.addr[AW-1:0] + 19'h00001;
          end
          default: begin
            s_nxt.st = ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.cs_s <= 3'h7;
      s_r.sck_s <= 3'h0;
      s_r.io_s1 <= 4'h0;
      s_r.io_s2 <= 4'h0;
      s_r.st <= ST_IDLE;
      s_r.op <= 8'h00;
      s_r.sh <= 8'h00;
      s_r.nb <= 4'h0;
      s_r.ab <= 2'h0;
      s_r.addr <= 24'h000000;
      s_r.cont <= 1'b0;
      s_r.we <= 1'b0;
      s_r.waddr <= '0;
      s_r.wdata <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Write latch flag is never cleared here
  assign mem_we = s_r.we;
  assign mem_addr = s_r.waddr;
  assign mem_wdata = s_r.wdata;
  assign cont_mode = s_r.cont;
endmodule

// file: smw_host.sv
// Purpose: Host controller sending serial write commands, driven over APB
// Assumes: Software sets opcode, address, mode and up to four data bytes
// Notes: Link clock is clk divided by eight, mode 0

`timescale 1ns/1ns

module smw_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  smw_if.host bus
);
  import smw_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] ph;
    logic act;
    logic pend;
    logic pddr;
    logic fresh;
    smw_ph_t bph;
    logic [1:0] idx;
    logic [7:0] sh;
    logic [3:0] left;
    logic cs_n;
    logic sck;
    logic [3:0] io;
    logic [3:0] oe;
    logic [7:0] op;
    logic [1:0] proto;
    logic [1:0] cnt;
    logic skip;
    logic [23:0] addr;
    logic [7:0] mode;
    logic [31:0] data;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } smw_host_t;

  smw_host_t s_r;
  smw_host_t s_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [2:0] w;
    logic [7:0] b;
    smw_ph_t cph;
    smw_ph_t uph;
    logic [1:0] cidx;
    logic cend;
    logic newb;
    logic ud;
    logic slot;
    rd = 32'h0;
    w = 3'h1;
    b = 8'h00;
    cph = PH_CMD;
    cidx = 2'h0;
    cend = 1'b0;
    uph = PH_CMD;
    newb = 1'b0;
    ud = 1'b0;
    slot = 1'b0;
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    // APB: answer in the second access cycle
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      rd[7:0] = s_r.op;
      rd[CTRL_PROTO_LSB +: 2] = s_r.proto;
      rd[CTRL_SKIP_BIT] = s_r.skip;
      rd[CTRL_CNT_LSB +: 2] = s_r.cnt;
      case (paddr)
        REG_CTRL: s_nxt.prdata = rd;
        REG_ADDR: s_nxt.prdata = {8'h00, s_r.addr};
        REG_MODE: s_nxt.prdata = {24'h0, s_r.mode};
        REG_DATA: s_nxt.prdata = s_r.data;
        REG_STAT: s_nxt.prdata = {31'h0, s_r.act};
        default: begin
          s_nxt.prdata = 32'h0;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    // Writes take effect only while idle
    if (psel && penable && s_r.pready && pwrite && !s_r.pslverr && !s_r.act) begin
      case (paddr)
        REG_CTRL: begin
          s_nxt.op = pwdata[7:0];
          s_nxt.proto = pwdata[CTRL_PROTO_LSB +: 2];
          s_nxt.skip = pwdata[CTRL_SKIP_BIT];
          s_nxt.cnt = pwdata[CTRL_CNT_LSB +: 2];
          if (pwdata[CTRL_GO_BIT]) begin
            s_nxt.act = 1'b1;
            s_nxt.cs_n = 1'b0;
            s_nxt.ph = SDR_SLOT_PH;
            s_nxt.fresh = 1'b1;
            s_nxt.left = 4'h0;
            s_nxt.pend = 1'b0;
          end
        end
        REG_ADDR: s_nxt.addr = pwdata[23:0];
        REG_MODE: s_nxt.mode = pwdata[7:0];
        REG_DATA: s_nxt.data = pwdata;
        default: s_nxt.op = s_r.op;
      endcase
    end
    if (s_r.act) begin
      s_nxt.ph = s_r.ph + 3'h1;
      // Clock idles low, data taken at rising edge
      if (s_r.ph == SCK_RISE_PH) begin
        s_nxt.sck = 1'b1;
        s_nxt.pend = 1'b0;
      end
      if (s_r.ph == SCK_FALL_PH) begin
        s_nxt.sck = 1'b0;
        if (s_r.pddr) s_nxt.pend = 1'b0;
      end
      // Byte that follows the current one
      if (s_r.fresh) begin
        cph = s_r.skip ? PH_ADDR : PH_CMD;
      end else begin
        case (s_r.bph)
          PH_CMD: cph = PH_ADDR;
          PH_ADDR: begin
            cph = (s_r.idx == ADDR_LAST) ? (smw_has_mode(s_r.op) ? PH_MODE : PH_DATA) : PH_ADDR;
            cidx = (s_r.idx == ADDR_LAST) ? 2'h0 : s_r.idx + 2'h1;
          end
          PH_MODE: cph = PH_DATA;
          default: begin
            cph = PH_DATA;
            cidx = s_r.idx + 2'h1;
            cend = (s_r.idx == s_r.cnt);
          end
        endcase
      end
      newb = (s_r.left == 4'h0);
      uph = newb ? cph : s_r.bph;
      ud = smw_ddr(s_r.op) && (uph != PH_CMD);
      slot = ud ? ((s_r.ph == DDR_SLOT_A) || (s_r.ph == DDR_SLOT_B)) : (s_r.ph == SDR_SLOT_PH);
      if (!s_r.pend && newb && cend && (s_r.ph == SDR_SLOT_PH)) begin
        // Deselect after the last data bit
        s_nxt.act = 1'b0;
        s_nxt.cs_n = 1'b1;
        s_nxt.oe = 4'h0;
      end else if (!s_r.pend && slot && !(newb && cend)) begin
        w = smw_lanes(s_r.op, s_r.proto, uph);
        case (cph)
          PH_CMD: b = s_r.op;
          PH_ADDR: b = (cidx == 2'h0) ? s_r.addr[23:16] : (cidx == 2'h1) ? s_r.addr[15:8] : s_r.addr[7:0];
          PH_MODE: b = s_r.mode;
          default: b = s_r.data[{cidx, 3'h0} +: 8];
        endcase
        if (!newb) b = s_r.sh;
        if (newb) begin
          s_nxt.bph = cph;
          s_nxt.idx = cidx;
          s_nxt.fresh = 1'b0;
        end
        // Msb first; two lanes put bit 7 on line 1
        s_nxt.io = (w == 3'h4) ? b[7:4] : (w == 3'h2) ? {2'h0, b[7:6]} : {3'h0, b[7]};
        s_nxt.oe = (w == 3'h4) ? 4'hf : (w == 3'h2) ? 4'h3 : 4'h1;
        s_nxt.sh = b << w;
        s_nxt.left = (newb ? BYTE_BITS : s_r.left) - {1'b0, w};
        s_nxt.pend = 1'b1;
        s_nxt.pddr = ud;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.cs_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign bus.cs_n = s_r.cs_n;
  assign bus.sck = s_r.sck;
  assign bus.io_o = s_r.io;
  assign bus.io_oe = s_r.oe;
endmodule

// file: smw_monitor.sv
// Purpose: Wire-level checks on the serial write link
// Assumes: Host reset is the reset of this domain
// Notes: Host link clock is eight clk a period

`timescale 1ns/1ns

module smw_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe,
  input wire logic [3:0] io
);
  // ----------------------------------------
  // Link clock and framing
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_clk_high;
    sck [*4] ##1 !sck;
  endsequence

  sequence s_clk_low;
    !sck [*4];
  endsequence

  chk_sck_idle_low:
    assert property (cs_n |-> !sck) else $error("link clock high while deselected");
  chk_sck_high_len:
    assert property ($rose(sck) |-> s_clk_high) else $error("link clock high phase not four cycles");
  chk_sck_low_len:
    assert property ($fell(sck) |-> s_clk_low) else $error("link clock low phase too short");
  chk_io_setup:
    assert property ($rose(sck) |-> $stable(io_o)) else $error("data changed at clock rise");
  chk_io_hold:
    assert property ($rose(sck) |=> $stable(io_o)) else $error("data changed right after clock rise");
  chk_cs_first_rise:
    assert property ($fell(cs_n) |-> ##[2:6] $rose(sck)) else $error("no clock rise after select");
  chk_cs_lane_zero:
    assert property ($fell(cs_n) |-> ##[0:2] io_oe[0]) else $error("lane zero not driven after select");
  chk_cs_end_clean:
    assert property ($rose(cs_n) |-> io_oe == 4'h0 && !$past(sck)) else $error("deselect not clean");
  chk_bus_pulled:
    assert property (cs_n && $past(cs_n) |-> io == 4'hf) else $error("idle lines not pulled high");
endmodule

// file: tb.sv
// Purpose: Both ends of the serial write link; host driven over APB, device settings driven directly
// Assumes: Host and device share clk; host reset separate
// Notes: Rows hold opcode, lanes, address, mode, data and flags

`timescale 1ns/1ns

module tb;
  import smw_pkg::*;
  typedef struct {logic [7:0] op; logic [1:0] pr; logic sk; logic [23:0] ad;
    logic [7:0] md; logic [1:0] nb; logic [31:0] dt; logic [2:0] f;} smw_row_t;
  logic clk, rst, rst_h, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, mem_wdata;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] proto;
  logic write_latch_flag, prot_en, mem_we, cont_mode;
  logic [AW-1:0] prot_lo, prot_hi, mem_addr, a;
  logic [AW-1:0] wa[$], ea[$];
  logic [7:0] wd[$], ed[$];
  int n_fail, checked, cyc;
  smw_row_t rows[16] = '{
    '{OP_WRITE, PROTO_SPI, 1'h0, 24'h000010, 8'h00, 2'h0, 32'h0000005a, 3'h4},
    '{OP_WRITE, PROTO_TWO, 1'h0, 24'h012345, 8'h00, 2'h1, 32'h0000c3a5, 3'h4},
    '{OP_WRITE, PROTO_FOUR, 1'h0, 24'hfffffe, 8'h00, 2'h3, 32'h87654321, 3'h4},
    '{OP_DDRW, PROTO_SPI, 1'h0, 24'h000100, 8'h00, 2'h1, 32'h00003c96, 3'h4},
    '{OP_FAST, PROTO_TWO, 1'h0, 24'h000200, 8'h5a, 2'h0, 32'h000000e1, 3'h4},
    '{OP_DDRFAST, PROTO_FOUR, 1'h0, 24'h000300, 8'h00, 2'h0, 32'h0000001e, 3'h4},
    '{OP_TWO_DATA, PROTO_SPI, 1'h0, 24'h000400, 8'h00, 2'h1, 32'h0000a55a, 3'h4},
    '{OP_TWO_ALL, PROTO_SPI, 1'h0, 24'h000500, 8'h81, 2'h0, 32'h0000000f, 3'h4},
    '{OP_FOUR_DATA, PROTO_SPI, 1'h0, 24'h000600, 8'h00, 2'h1, 32'h0000b47d, 3'h4},
    '{OP_FOUR_ALL, PROTO_SPI, 1'h0, 24'h000700, 8'h00, 2'h0, 32'h000000c6, 3'h4},
    '{OP_DDR_FOUR, PROTO_SPI, 1'h0, 24'h000800, 8'ha5, 2'h0, 32'h00000039, 3'h5},
    '{OP_DDR_FOUR, PROTO_SPI, 1'h1, 24'h000900, 8'hac, 2'h0, 32'h00000072, 3'h5},
    '{OP_DDR_FOUR, PROTO_SPI, 1'h1, 24'h000a00, 8'h5a, 2'h0, 32'h0000008d, 3'h4},
    '{OP_WRITE, PROTO_SPI, 1'h0, 24'h000b00, 8'h00, 2'h0, 32'h000000ff, 3'h0},
    '{OP_WRITE, PROTO_SPI, 1'h0, 24'h00001f, 8'h00, 2'h3, 32'h44332211, 3'h6},
    '{OP_WRITE, PROTO_SPI, 1'h0, 24'h000020, 8'h00, 2'h2, 32'h00665544, 3'h6}};

  smw_if bus();
  smw_host i_smw_host (.clk(clk), .rst(rst_h), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
  smw_dev i_smw_dev (.clk(clk), .rst(rst), .bus(bus), .proto(proto), .write_latch_flag(write_latch_flag),
    .prot_en(prot_en), .prot_lo(prot_lo), .prot_hi(prot_hi), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .cont_mode(cont_mode));
  smw_monitor i_smw_monitor (.clk(clk), .rst(rst_h), .cs_n(bus.cs_n), .sck(bus.sck),
    .io_o(bus.io_o), .io_oe(bus.io_oe), .io(bus.io));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic run(input smw_row_t r, input logic hold);
    proto <= r.pr;
    write_latch_flag <= r.f[2];
    prot_en <= r.f[1];
    wa.delete();
    wd.delete();
    apb(1'h1, REG_ADDR, {8'h00, r.ad});
    apb(1'h1, REG_MODE, {24'h0, r.md});
    apb(1'h1, REG_DATA, r.dt);
    apb(1'h1, REG_CTRL, {1'h1, 18'h0, r.nb, r.sk, r.pr, r.op});
    rd = 32'h1;
    while (!hold && rd[0] === 1'h1)
      apb(1'h0, REG_STAT, 32'h0);
    if (!hold)
      repeat (16) @(posedge clk);
  endtask

  // ----------------------------------------
  // Clock, capture, timeout
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (mem_we === 1'h1) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
    end
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'h1;
    rst_h = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {proto, write_latch_flag, prot_en} = '0;
    prot_lo = 19'h00020;
    prot_hi = 19'h00021;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rst_h <= 1'h0;
    foreach (rows[k]) begin
      run(rows[k], 1'h0);
      ea.delete();
      ed.delete();
      for (int i = 0; i <= rows[k].nb; i++) begin
        a = rows[k].ad[AW-1:0] + AW'(i);
        if (rows[k].f[2] && !(rows[k].f[1] && a >= prot_lo && a <= prot_hi)) begin
          ea.push_back(a);
          ed.push_back(rows[k].dt[8*i+:8]);
        end
      end
      chk(32'(wa.size()), 32'(ea.size()));
      foreach (ea[i]) begin
        chk({13'h0, wa[i]}, {13'h0, ea[i]});
        chk({24'h0, wd[i]}, {24'h0, ed[i]});
      end
      chk({31'h0, cont_mode}, {31'h0, rows[k].f[0]});
    end
    // Host reset in mid byte drops that byte only
    run(rows[1], 1'h1);
    for (int n = 0; n < 2000 && wa.size() == 0; n++)
      @(posedge clk);
    repeat (12) @(posedge clk);
    rst_h <= 1'h1;
    repeat (2) @(posedge clk);
    rst_h <= 1'h0;
    repeat (40) @(posedge clk);
    chk(32'(wa.size()), 32'h1);
    // Unmapped register
    apb(1'h0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // Reset values
    rst <= 1'h1;
    rst_h <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rst_h <= 1'h0;
    apb(1'h0, REG_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk({13'h0, mem_addr}, 32'h0);
    chk({28'h0, bus.io}, 32'hf);
    // Mode register reads back what was written
    apb(1'h1, REG_MODE, 32'h000000a7);
    apb(1'h0, REG_MODE, 32'h0);
    chk(rd, 32'h000000a7);
    chk({31'h0, er}, 32'h0);
    finish_test();
  end
endmodule
